// ### pkg/flash_checker_pkg.sv
package flash_checker_pkg;
  // Register indices; the byte address is four times the index
  localparam logic [7:0] IDX_CONTROL = 8'h00;
  localparam logic [7:0] IDX_SOURCE = 8'h01;
  localparam logic [7:0] IDX_STATUS = 8'h02;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h03;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h04;
  localparam logic [7:0] IDX_BOOT_INIT = 8'h05;
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_SOURCE = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;
  localparam logic [7:0] ADDR_BOOT_INIT = 8'h14;
  // Field positions
  localparam int CTL_ENABLE = 0;
  localparam int CTL_IRQEN = 1;
  localparam int CTL_SELF_RESET = 7;
  localparam int ST_BUSY = 0;
  localparam int ST_PASS = 1;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_FAIL = 1;
  // Reset values
  localparam logic [7:0] STATUS_RESET = 8'h02;
  localparam logic [1:0] SOURCE_RESET = 2'h0;
  // Section encodings
  localparam logic [1:0] SEC_FULL = 2'h0;
  localparam logic [1:0] SEC_BOOT_APP = 2'h1;
  localparam logic [1:0] SEC_BOOT = 2'h2;
  // Timing and CRC constants
  localparam int START_DELAY = 3;
  localparam int FETCH_PERIOD = 3;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_WAIT = 2'b01,
    S_SCAN = 2'b11
  } scan_state_t;
endpackage

// ### rtl/flash_crc_scanner.sv
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/1ps
// Notes on behaviour
// - Writing one to enable starts a check; enable stays one, rewrite restarts.
// - Writing zero to enable never aborts a running check.
// - Failure in a finishing check still reports; interrupt request only with interrupt enable set.
// - Check started at boot leaves enable reading one afterwards.
// - Busy reads one for the whole duration of a check.
// - Section register writes ignored while busy or after interrupt raised.
// - Section codes: 0 full, 1 boot plus application, 2 boot, 3 also full.
// - Check started at boot leaves section selector showing scanned region.
// - Status register ignores writes and resets to 0x02.
// - Pass flag is one after reset, cleared when checker is enabled.
// - Pass reads zero while checking, one after clean finish, reset or self-reset.
// - While busy, section and interrupt-enable changes are blocked.
// - Failing check with interrupt enable raises request held until reset.
// - Fetching begins five cycles after enable written; CPU runs meanwhile.
// - Checker has flash priority, stalls CPU, fetches every third cycle.
// - Self-reset strobe clears control and status one cycle later, not irqen.
module flash_crc_scanner #(
  parameter int ADDR_W = 16,
  parameter logic [15:0] BOOT_END_WORDS = 16'h0100,
  parameter logic [15:0] APP_END_WORDS = 16'h0400,
  parameter logic [15:0] FLASH_END_WORDS = 16'h0800
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic boot_scan_req,
  input wire logic [1:0] boot_scan_section,
  output logic [ADDR_W-1:0] flash_addr,
  output logic flash_rd,
  input wire logic [15:0] flash_rdata,
  output logic cpu_stall,
  output logic nmi_req,
  output logic irq
);
  if (ADDR_W < 2 || ADDR_W > 16) begin : g_bad_addr_w
    $error("ADDR_W out of range");
  end

  function automatic logic [15:0] crc_step(input logic [15:0] c,
                                           input logic [15:0] w);
    logic [15:0] r;
    r = c;
    for (int i = 15; i >= 0; i--) begin
      r = (r[15] ^ w[i]) ? ((r << 1) ^ flash_checker_pkg::CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  function automatic logic [ADDR_W-1:0] sec_last(input logic [1:0] s);
    unique case (s)
      flash_checker_pkg::SEC_BOOT_APP: sec_last = APP_END_WORDS[ADDR_W-1:0] - 1'b1;
      flash_checker_pkg::SEC_BOOT: sec_last = BOOT_END_WORDS[ADDR_W-1:0] - 1'b1;
      default: sec_last = FLASH_END_WORDS[ADDR_W-1:0] - 1'b1;
    endcase
  endfunction

  // Bus handshake state
  logic aw_have_q, aw_have_d, w_have_q, w_have_d;
  logic [7:0] aw_q, aw_d;
  logic [31:0] wd_q, wd_d;
  logic [3:0] ws_q, ws_d;
  logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  // Block state
  flash_checker_pkg::scan_state_t st_q, st_d;
  logic enable_q, enable_d, irqen_q, irqen_d, srst_q, srst_d;
  logic [1:0] sec_q, sec_d;
  logic busy_q, busy_d, pass_q, pass_d, nmi_q, nmi_d;
  logic [1:0] cnt_q, cnt_d;
  logic [ADDR_W-1:0] addr_q, addr_d, last_q, last_d;
  logic [15:0] crc_q, crc_d;
  logic rd_q, rd_d, boot_done_q, boot_done_d;
  logic [1:0] ist_q, ist_d, imask_q, imask_d;
  logic irq_q, irq_d;
  logic awready_q, awready_d, wready_q, wready_d, arready_q, arready_d;
  logic stall_q, stall_d;

  logic wr_go, rd_go, start;
  logic [7:0] wbyte, waddr8, raddr8;
  logic [1:0] ev;

  assign waddr8 = aw_have_q ? aw_q : s_axi_awaddr[7:0];
  assign wbyte = w_have_q ? wd_q[7:0] : s_axi_wdata[7:0];
  assign wr_go = (aw_have_q || s_axi_awvalid) && (w_have_q || s_axi_wvalid)
                 && !bvalid_q;
  assign rd_go = s_axi_arvalid && !rvalid_q;
  assign raddr8 = s_axi_araddr[7:0];
  assign start = (wr_go && (w_have_q ? ws_q[0] : s_axi_wstrb[0])
                 && waddr8 == flash_checker_pkg::ADDR_CONTROL && !nmi_q
                 && wbyte[flash_checker_pkg::CTL_ENABLE]
                 && !wbyte[flash_checker_pkg::CTL_SELF_RESET])
                 || (boot_scan_req && !boot_done_q);

  always_comb begin
    logic wlane;
    wlane = w_have_q ? ws_q[0] : s_axi_wstrb[0];
    aw_have_d = aw_have_q;
    w_have_d = w_have_q;
    aw_d = aw_q;
    wd_d = wd_q;
    ws_d = ws_q;
    bvalid_d = bvalid_q && !s_axi_bready;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q && !s_axi_rready;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    st_d = st_q;
    enable_d = enable_q;
    irqen_d = irqen_q;
    srst_d = 1'b0;
    sec_d = sec_q;
    busy_d = busy_q;
    pass_d = pass_q;
    nmi_d = nmi_q;
    cnt_d = cnt_q;
    addr_d = addr_q;
    last_d = last_q;
    crc_d = crc_q;
    rd_d = 1'b0;
    boot_done_d = boot_done_q || boot_scan_req;
    imask_d = imask_q;
    ev = 2'b00;
    if (s_axi_awvalid && !aw_have_q && !wr_go) begin
      aw_have_d = 1'b1;
      aw_d = s_axi_awaddr[7:0];
    end
    if (s_axi_wvalid && !w_have_q && !wr_go) begin
      w_have_d = 1'b1;
      wd_d = s_axi_wdata;
      ws_d = s_axi_wstrb;
    end
    unique case (st_q)
      flash_checker_pkg::S_IDLE: ;
      flash_checker_pkg::S_WAIT: begin
        // CPU keeps running during the start delay
        cnt_d = cnt_q + 2'd1;
        if (cnt_q == 2'(flash_checker_pkg::START_DELAY - 1)) begin
          st_d = flash_checker_pkg::S_SCAN;
          cnt_d = 2'd0;
        end
      end
      flash_checker_pkg::S_SCAN: begin
        cnt_d = (cnt_q == 2'(flash_checker_pkg::FETCH_PERIOD - 1)) ? 2'd0
                : cnt_q + 2'd1;
        if (cnt_q == 2'd0) rd_d = 1'b1;
        if (rd_q) begin
          crc_d = crc_step(crc_q, flash_rdata);
          if (addr_q == last_q) begin
            st_d = flash_checker_pkg::S_IDLE;
            busy_d = 1'b0;
            ev[flash_checker_pkg::IRQ_DONE] = 1'b1;
            // Stored checksum folds in, leaving zero on a clean section
            if (crc_step(crc_q, flash_rdata) == 16'h0000) begin
              pass_d = 1'b1;
            end else begin
              pass_d = 1'b0;
              ev[flash_checker_pkg::IRQ_FAIL] = 1'b1;
              if (irqen_q) nmi_d = 1'b1;
            end
          end else begin
            addr_d = addr_q + 1'b1;
          end
        end
      end
      default: st_d = flash_checker_pkg::S_IDLE;
    endcase
    // Delayed self-reset wins over the scan sequencer in any state
    if (srst_q) begin
      enable_d = 1'b0;
      sec_d = flash_checker_pkg::SOURCE_RESET;
      busy_d = flash_checker_pkg::STATUS_RESET[flash_checker_pkg::ST_BUSY];
      pass_d = flash_checker_pkg::STATUS_RESET[flash_checker_pkg::ST_PASS];
      st_d = flash_checker_pkg::S_IDLE;
    end
    if (start) begin
      enable_d = 1'b1;
      busy_d = 1'b1;
      pass_d = 1'b0;
      st_d = flash_checker_pkg::S_WAIT;
      cnt_d = 2'd0;
      addr_d = '0;
      crc_d = flash_checker_pkg::CRC_INIT;
      if (boot_scan_req && !boot_done_q) begin
        sec_d = boot_scan_section;
        last_d = sec_last(boot_scan_section);
      end else begin
        last_d = sec_last(sec_q);
      end
    end
    if (wr_go) begin
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = 2'b00;
      unique case (waddr8)
        flash_checker_pkg::ADDR_CONTROL: begin
          // Writes blocked after interrupt raised; zero does not abort
          if (wlane && !nmi_q) begin
            if (!wbyte[flash_checker_pkg::CTL_ENABLE] && !busy_q)
              enable_d = 1'b0;
            if (wbyte[flash_checker_pkg::CTL_IRQEN] && !busy_q)
              irqen_d = 1'b1;
            if (wbyte[flash_checker_pkg::CTL_SELF_RESET]
                && (!irqen_q || !busy_q))
              srst_d = 1'b1;
          end
        end
        flash_checker_pkg::ADDR_SOURCE: begin
          if (wlane && !busy_q && !nmi_q && !start)
            sec_d = wbyte[1:0];
        end
        flash_checker_pkg::ADDR_STATUS: ;
        flash_checker_pkg::ADDR_IRQ_STATUS: ;
        flash_checker_pkg::ADDR_IRQ_MASK: begin
          if (wlane) imask_d = wbyte[1:0];
        end
        flash_checker_pkg::ADDR_BOOT_INIT: ;
        default: bresp_d = 2'b10;
      endcase
    end
    // Set wins over write-one-to-clear
    ist_d = ist_q;
    if (wr_go && wlane && waddr8 == flash_checker_pkg::ADDR_IRQ_STATUS)
      ist_d = ist_q & ~wbyte[1:0];
    ist_d = ist_d | ev;
    irq_d = |(ist_d & imask_d);
    if (rd_go) begin
      rvalid_d = 1'b1;
      rresp_d = 2'b00;
      rdata_d = '0;
      unique case (raddr8)
        flash_checker_pkg::ADDR_CONTROL:
          rdata_d[1:0] = {irqen_q, enable_q};
        flash_checker_pkg::ADDR_SOURCE: rdata_d[1:0] = sec_q;
        flash_checker_pkg::ADDR_STATUS: rdata_d[1:0] = {pass_q, busy_q};
        flash_checker_pkg::ADDR_IRQ_STATUS: rdata_d[1:0] = ist_q;
        flash_checker_pkg::ADDR_IRQ_MASK: rdata_d[1:0] = imask_q;
        flash_checker_pkg::ADDR_BOOT_INIT: rdata_d[0] = nmi_q;
        default: rresp_d = 2'b10;
      endcase
    end
    // Ready and stall outputs registered from the next state
    awready_d = !aw_have_d && !bvalid_d;
    wready_d = !w_have_d && !bvalid_d;
    arready_d = !rvalid_d;
    stall_d = (st_d == flash_checker_pkg::S_SCAN);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_q <= 8'h00;
      wd_q <= 32'h0000_0000;
      ws_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= 2'h0;
      rvalid_q <= 1'b0;
      rresp_q <= 2'h0;
      rdata_q <= 32'h0000_0000;
      st_q <= flash_checker_pkg::S_IDLE;
      enable_q <= 1'b0;
      irqen_q <= 1'b0;
      srst_q <= 1'b0;
      sec_q <= flash_checker_pkg::SOURCE_RESET;
      busy_q <= flash_checker_pkg::STATUS_RESET[flash_checker_pkg::ST_BUSY];
      pass_q <= flash_checker_pkg::STATUS_RESET[flash_checker_pkg::ST_PASS];
      nmi_q <= 1'b0;
      cnt_q <= 2'h0;
      addr_q <= '0;
      last_q <= '0;
      crc_q <= 16'h0000;
      rd_q <= 1'b0;
      boot_done_q <= 1'b0;
      ist_q <= 2'h0;
      imask_q <= 2'h0;
      irq_q <= 1'b0;
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      arready_q <= 1'b1;
      stall_q <= 1'b0;
    end else begin
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      aw_q <= aw_d;
      wd_q <= wd_d;
      ws_q <= ws_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
      st_q <= st_d;
      enable_q <= enable_d;
      irqen_q <= irqen_d;
      srst_q <= srst_d;
      sec_q <= sec_d;
      busy_q <= busy_d;
      pass_q <= pass_d;
      nmi_q <= nmi_d;
      cnt_q <= cnt_d;
      addr_q <= addr_d;
      last_q <= last_d;
      crc_q <= crc_d;
      rd_q <= rd_d;
      boot_done_q <= boot_done_d;
      ist_q <= ist_d;
      imask_q <= imask_d;
      irq_q <= irq_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      arready_q <= arready_d;
      stall_q <= stall_d;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;
  assign flash_addr = addr_q;
  assign flash_rd = rd_q;
  assign cpu_stall = stall_q;
  assign nmi_req = nmi_q;
  assign irq = irq_q;

  property p_start_busy;
    @(posedge aclk) disable iff (!aresetn)
      start |=> busy_q && !pass_q;
  endproperty
  a_start_busy: assert property (p_start_busy)
    else $error("start did not set busy and clear pass");

  property p_busy_no_pass;
    @(posedge aclk) disable iff (!aresetn)
      busy_q |-> !pass_q;
  endproperty
  a_busy_no_pass: assert property (p_busy_no_pass)
    else $error("pass high while busy");

  property p_fetch_delay;
    @(posedge aclk) disable iff (!aresetn)
      (start && !busy_q) |-> !flash_rd [*5] ##1 flash_rd;
  endproperty
  a_fetch_delay: assert property (p_fetch_delay)
    else $error("first fetch not at expected delay");

  property p_fetch_spacing;
    @(posedge aclk) disable iff (!aresetn)
      (flash_rd && busy_q && !start && !srst_q && !srst_d && addr_q != last_q)
        |=> !flash_rd ##1 !flash_rd ##1 (flash_rd || !busy_q);
  endproperty
  a_fetch_spacing: assert property (p_fetch_spacing)
    else $error("fetch spacing not three cycles");

  property p_nmi_sticky;
    @(posedge aclk) disable iff (!aresetn)
      nmi_q |=> nmi_q;
  endproperty
  a_nmi_sticky: assert property (p_nmi_sticky)
    else $error("interrupt request dropped before reset");

  property p_nmi_cause;
    @(posedge aclk) disable iff (!aresetn)
      $rose(nmi_q) |-> !pass_q && $fell(busy_q) && irqen_q;
  endproperty
  a_nmi_cause: assert property (p_nmi_cause)
    else $error("interrupt without failing check");

  property p_sec_locked;
    @(posedge aclk) disable iff (!aresetn)
      (busy_q && !srst_q && !$past(srst_q)) |=> $stable(sec_q) || !busy_q;
  endproperty
  a_sec_locked: assert property (p_sec_locked)
    else $error("section changed while busy");

  property p_srst;
    @(posedge aclk) disable iff (!aresetn)
      srst_q |=> !busy_q && pass_q && !enable_q && sec_q == 2'h0;
  endproperty
  a_srst: assert property (p_srst)
    else $error("self reset did not clear registers");

  property p_done_together;
    @(posedge aclk) disable iff (!aresetn)
      $fell(busy_q) && !$past(srst_q) |-> pass_q || nmi_q || !irqen_q;
  endproperty
  a_done_together: assert property (p_done_together)
    else $error("busy fell without pass or failure report");
endmodule // flash_crc_scanner

// ### tb/flash_model.sv
`timescale 1ns/1ps
module flash_model #(
  parameter int WORDS = 16
) (
  input wire logic [15:0] flash_addr,
  input wire logic flash_rd,
  output logic [15:0] flash_rdata
);
  logic [15:0] mem [WORDS];
  // Outside a fetch the bus shows the inverse, so stale data never matches
  assign flash_rdata = flash_rd ? mem[flash_addr % WORDS] :
                       ~mem[flash_addr % WORDS];
endmodule // flash_model

// ### tb/tb_flash_crc_scanner.sv
`timescale 1ns/1ps
module tb_flash_crc_scanner;
  logic aclk = 0;
  logic aresetn = 0;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata, v;
  logic awvalid = 0, wvalid = 0, arvalid = 0, req = 0;
  logic bready = 0, rready = 0;
  logic [3:0] wstrb = 4'hf;
  logic [1:0] sec = '0, bresp, rresp, r;
  logic awready, wready, bvalid, arready, rvalid, rd, stall, nmi, irq;
  logic [15:0] faddr, fdata, l_addr;
  int fails = 0, n_compared = 0, rd_cnt = 0, cyc = 0, e_cyc, l_cyc;
  int mode = 0;
  always #12.5 aclk = ~aclk;
  flash_crc_scanner #(.ADDR_W(16), .BOOT_END_WORDS(16'h0004),
    .APP_END_WORDS(16'h0008), .FLASH_END_WORDS(16'h0010))
  u_flash_crc_scanner (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .boot_scan_req(req), .boot_scan_section(sec),
    .flash_addr(faddr), .flash_rd(rd), .flash_rdata(fdata),
    .cpu_stall(stall), .nmi_req(nmi), .irq(irq));
  flash_model #(.WORDS(16)) u_flash_model (.flash_addr(faddr),
    .flash_rd(rd), .flash_rdata(fdata));
  task automatic summarize();
    $display("compared %0d, failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic check(input string n, input logic [31:0] s, e);
    n_compared++;
    if (s !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic timeout();
    fails++;
    summarize();
  endtask
  // Section checksums sit in the last word so each section sums to zero
  task automatic fill();
    logic [15:0] c;
    c = flash_checker_pkg::CRC_INIT;
    for (int i = 0; i < 16; i++) begin
      if (i == 3 || i == 7 || i == 15) begin
        u_flash_model.mem[i] = c;
      end else begin
        u_flash_model.mem[i] = 16'h1234 + 16'(i) * 16'h0111;
      end
      for (int b = 15; b >= 0; b--) begin
        c = {c[14:0], 1'b0} ^ ((c[15] ^ u_flash_model.mem[i][b]) ?
            flash_checker_pkg::CRC_POLY : 16'h0000);
      end
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    awaddr <= {24'h00_0000, a};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    r = bresp;
    if (n == 50) timeout();
  endtask
  task automatic rdr(input logic [7:0] a);
    int n;
    araddr <= {24'h00_0000, a};
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    v = rdata;
    r = rresp;
    if (n == 50) timeout();
  endtask
  task automatic rchk(input string n, input logic [7:0] a, e);
    rdr(a);
    check(n, v, {24'h00_0000, e});
  endtask
  task automatic wait_idle();
    int n;
    for (n = 0; n < 300; n++) begin
      rdr(flash_checker_pkg::ADDR_STATUS);
      if (v[0] === 1'b0) break;
    end
    if (n == 300) timeout();
  endtask
  task automatic start(input logic [1:0] s, input logic [7:0] ctl);
    rd_cnt = 0;
    wr(flash_checker_pkg::ADDR_SOURCE, {30'h0, s});
    wr(flash_checker_pkg::ADDR_CONTROL, {24'h00_0000, ctl});
    rchk("busy", flash_checker_pkg::ADDR_STATUS, 8'h01);
  endtask
  task automatic finish(input int words, input logic [7:0] st);
    wait_idle();
    check("done_status", v, {24'h00_0000, st});
    check("words", rd_cnt, words);
    check("last_addr", l_addr, 16'(words - 1));
  endtask
  // Fetch timing monitor
  always @(posedge aclk) begin
    cyc++;
    if (awvalid && awready && wvalid && wready && wstrb[0] && wdata[0] &&
        awaddr[7:0] == flash_checker_pkg::ADDR_CONTROL) begin
      e_cyc = cyc;
      mode = 1;
    end
    if (rd === 1'b1) begin
      if (mode == 1) check("start_delay", cyc - e_cyc, 5);
      if (mode == 0) check("gap", cyc - l_cyc, 3);
      check("stall", stall, 1'b1);
      mode = 0;
      rd_cnt++;
      l_addr = faddr;
      l_cyc = cyc;
    end
  end
  initial begin
    fill();
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rchk("status", flash_checker_pkg::ADDR_STATUS, 8'h02);
    rchk("source", flash_checker_pkg::ADDR_SOURCE, 8'h00);
    rchk("control", flash_checker_pkg::ADDR_CONTROL, 8'h00);
    wr(flash_checker_pkg::ADDR_STATUS, 32'h0000_0001);
    rchk("status_ro", flash_checker_pkg::ADDR_STATUS, 8'h02);
    rdr(8'h40);
    check("unmapped", r, 2'b10);
    wstrb <= 4'h0;
    wr(flash_checker_pkg::ADDR_SOURCE, 32'h0000_0002);
    wstrb <= 4'hf;
    rchk("strobe_off", flash_checker_pkg::ADDR_SOURCE, 8'h00);
    for (int s = 0; s < 4; s++) begin
      start(2'(s), 8'h01);
      finish(s == 2 ? 4 : (s == 1 ? 8 : 16), 8'h02);
      rchk("enable_kept", flash_checker_pkg::ADDR_CONTROL, 8'h01);
      rchk("section", flash_checker_pkg::ADDR_SOURCE, 8'(s));
    end
    rchk("done_flag", flash_checker_pkg::ADDR_IRQ_STATUS, 8'h01);
    check("irq_masked", irq, 1'b0);
    wr(flash_checker_pkg::ADDR_IRQ_STATUS, 32'h0000_0001);
    rchk("w1c", flash_checker_pkg::ADDR_IRQ_STATUS, 8'h00);
    start(2'h0, 8'h01);
    wr(flash_checker_pkg::ADDR_SOURCE, 32'h0000_0002);
    wr(flash_checker_pkg::ADDR_CONTROL, 32'h0000_0002);
    finish(16, 8'h02);
    rchk("irqen_blocked", flash_checker_pkg::ADDR_CONTROL, 8'h01);
    rchk("src_blocked", flash_checker_pkg::ADDR_SOURCE, 8'h00);
    start(2'h2, 8'h01);
    wr(flash_checker_pkg::ADDR_CONTROL, 32'h0000_0080);
    repeat (2) @(posedge aclk);
    rchk("sr_control", flash_checker_pkg::ADDR_CONTROL, 8'h00);
    rchk("sr_source", flash_checker_pkg::ADDR_SOURCE, 8'h00);
    rchk("sr_status", flash_checker_pkg::ADDR_STATUS, 8'h02);
    wr(flash_checker_pkg::ADDR_IRQ_MASK, 32'h0000_0002);
    u_flash_model.mem[1] = ~u_flash_model.mem[1];
    start(2'h2, 8'h03);
    wr(flash_checker_pkg::ADDR_CONTROL, 32'h0000_0002);
    finish(4, 8'h00);
    check("nmi", nmi, 1'b1);
    check("irq_fail", irq, 1'b1);
    rchk("nmi_read", flash_checker_pkg::ADDR_BOOT_INIT, 8'h01);
    wr(flash_checker_pkg::ADDR_IRQ_STATUS, 32'h0000_0003);
    wr(flash_checker_pkg::ADDR_SOURCE, 32'h0000_0001);
    rchk("src_after_nmi", flash_checker_pkg::ADDR_SOURCE, 8'h02);
    check("irq_clear", irq, 1'b0);
    check("nmi_held", nmi, 1'b1);
    aresetn <= 1'b0;
    sec <= 2'h1;
    repeat (4) @(posedge aclk);
    fill();
    aresetn <= 1'b1;
    @(posedge aclk);
    req <= 1'b1;
    mode = 2;
    rd_cnt = 0;
    @(posedge aclk);
    req <= 1'b0;
    wait_idle();
    check("boot_status", v, 32'h0000_0002);
    check("boot_words", rd_cnt, 8);
    rchk("boot_enable", flash_checker_pkg::ADDR_CONTROL, 8'h01);
    rchk("boot_section", flash_checker_pkg::ADDR_SOURCE, 8'h01);
    check("nmi_reset", nmi, 1'b0);
    summarize();
  end
endmodule // tb_flash_crc_scanner
